// >>> common/adcaux_pkg.sv
// shared constants for the auxiliary pin serial link
package adcaux_pkg;
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_BITS_5 = 5'h10;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 12;
  localparam logic [3:0] CMD_PIN_CFG = 4'h4;
  localparam logic [3:0] CMD_MODE_A = 4'h1;
  localparam logic [3:0] CMD_MODE_B = 4'h2;
  localparam logic [3:0] CMD_MODE_C = 4'h3;
  // pin configuration fields
  localparam int SOFT_RST_BIT = 9;
  localparam int PD_ASSIGN_BIT = 8;
  localparam int RANGE_ASSIGN_BIT = 7;
  localparam int ALARM_B2 = 6;
  localparam int ALARM_B1 = 5;
  localparam int ALARM_B0 = 4;
  localparam logic [11:0] CFG_RESET = 12'h000;
  // mode frame fields
  localparam int RANGE_BIT = 6;
  localparam int SLEEP_BIT = 5;
  localparam int READBACK_BIT = 4;
  localparam logic [3:0] OUT_DATA_RESET = 4'h0;
  // link timing
  localparam int PCLK_NS = 20;
  localparam int SCLK_HALF_NS = 120;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
  // host register offsets
  localparam logic [7:0] OFS_TX = 8'h00;
  localparam logic [7:0] OFS_RX = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam int INT_DONE = 0;
  localparam int INT_REFUSED = 1;
  localparam logic [1:0] INT_RESET = 2'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // host sequencer states
  typedef enum logic [2:0] {
    ADCAUX_IDLE = 3'h0,
    ADCAUX_LEAD = 3'h1,
    ADCAUX_HIGH = 3'h3,
    ADCAUX_LOW = 3'h2,
    ADCAUX_GAP = 3'h6
  } adcaux_state_t;
endpackage

// >>> common/adcaux_link_if.sv
// serial link between host controller and auxiliary pin device
`timescale 1ns/1ns
interface adcaux_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  modport dev (input cs_n, input sclk, input sdi, output sdo);
  modport host (output cs_n, output sclk, output sdi, input sdo);
endinterface

// >>> design/adcaux_sync.sv
// three-stage synchroniser with settled level and edge pulses
`timescale 1ns/1ns
module adcaux_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous inputs
  input wire logic [W-1:0] d,
  // settled level and one-cycle edges
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;
  logic [W-1:0] agree;

  // three flops; only the second reads the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg <= '0;
    end else begin
      lvl_reg <= (agree & s3_reg) | (~agree & lvl_reg);
    end
  end

  // edges fire one cycle before the level flop follows
  assign rise = agree & s3_reg & ~lvl_reg;
  assign fall = agree & ~s3_reg & lvl_reg;
  assign lvl = lvl_reg;
endmodule // adcaux_sync

// >>> design/adcaux_device.sv
// auxiliary pin configuration end of the converter serial link
`timescale 1ns/1ns
module adcaux_device
  import adcaux_pkg::*;
#(
  parameter int DW = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  adcaux_link_if.dev link,
  // auxiliary pins, index 0 is aux_pin_zero
  input wire logic [3:0] aux_pin_in,
  output logic [3:0] aux_pin_out,
  output logic [3:0] aux_pin_oe,
  // conversion results from the converter core
  input wire logic conv_strobe,
  input wire logic [DW-1:0] conv_result,
  input wire logic [DW-1:0] conv_high_limit,
  input wire logic [DW-1:0] conv_low_limit,
  // device status
  output logic powered_down,
  output logic range_select,
  output logic alarm_high,
  output logic alarm_low,
  output logic [11:0] pin_config
);
  // ----------------------------------------------------------------
  // link sampling
  // ----------------------------------------------------------------
  logic [2:0] lnk_lvl;
  logic [2:0] lnk_rise;
  logic [2:0] lnk_fall;
  logic [3:0] pin_lvl;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  adcaux_sync #(.W(3)) u_link_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.sdi, link.sclk, link.cs_n}),
    .lvl(lnk_lvl),
    .rise(lnk_rise),
    .fall(lnk_fall)
  );

  adcaux_sync #(.W(4)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(aux_pin_in),
    .lvl(pin_lvl),
    .rise(),
    .fall()
  );

  assign cs_fall = lnk_fall[0];
  assign cs_rise = lnk_rise[0];
  assign sclk_rise = lnk_rise[1] & ~lnk_lvl[0];
  assign sclk_fall = lnk_fall[1] & ~lnk_lvl[0];

  // ----------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------
  logic [15:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic frame_done;
  logic [3:0] frame_command_field;
  logic is_cfg;
  logic is_mode;
  logic soft_rst;

  // msb first on sclk rising while selected; count saturates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= WORD_RESET;
      bit_cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      bit_cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[14:0], lnk_lvl[2]};
      if (bit_cnt_reg != 5'h1F) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // short or long frames are dropped whole
  assign frame_done = cs_rise && (bit_cnt_reg == FRAME_BITS_5);
  assign frame_command_field = shift_reg[CMD_HI:CMD_LO];
  assign is_cfg = frame_done && (frame_command_field == CMD_PIN_CFG);
  assign is_mode = frame_done && (frame_command_field == CMD_MODE_A ||
                                  frame_command_field == CMD_MODE_B ||
                                  frame_command_field == CMD_MODE_C);

  // ----------------------------------------------------------------
  // pin configuration register
  // ----------------------------------------------------------------
  logic [11:0] cfg_reg;

  // the stored reset bit is the pending soft reset itself
  assign soft_rst = cs_fall && cfg_reg[SOFT_RST_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_RESET;
    end else if (soft_rst) begin
      cfg_reg <= CFG_RESET;
    end else if (is_cfg) begin
      cfg_reg <= shift_reg[11:0];
    end
  end

  assign pin_config = cfg_reg;

  // ----------------------------------------------------------------
  // mode frame fields
  // ----------------------------------------------------------------
  logic [3:0] out_pend_reg;
  logic input_readback_enable;
  logic sleep_request_bit;
  logic range_bit_reg;

  // configuration frames never touch these, so data and range hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pend_reg <= OUT_DATA_RESET;
      input_readback_enable <= 1'b0;
      sleep_request_bit <= 1'b0;
      range_bit_reg <= 1'b0;
    end else if (soft_rst) begin
      out_pend_reg <= OUT_DATA_RESET;
      input_readback_enable <= 1'b0;
      sleep_request_bit <= 1'b0;
      range_bit_reg <= 1'b0;
    end else if (is_mode) begin
      out_pend_reg <= shift_reg[3:0];
      input_readback_enable <= shift_reg[READBACK_BIT];
      sleep_request_bit <= shift_reg[SLEEP_BIT];
      range_bit_reg <= shift_reg[RANGE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // chip-select falling edge: outputs, inputs, serial answer
  // ----------------------------------------------------------------
  logic [3:0] pin_output_data;
  logic [15:0] sdo_shift_reg;
  logic [DW-1:0] result_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_output_data <= OUT_DATA_RESET;
    end else if (soft_rst) begin
      pin_output_data <= OUT_DATA_RESET;
    end else if (cs_fall) begin
      pin_output_data <= out_pend_reg;
    end
  end

  // answer: pin states (or zero), result, two pad bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_shift_reg <= WORD_RESET;
    end else if (cs_fall) begin
      sdo_shift_reg <= {input_readback_enable ? pin_lvl : 4'h0,
                        result_reg, 2'b00};
    end else if (sclk_fall) begin
      sdo_shift_reg <= {sdo_shift_reg[14:0], 1'b0};
    end
  end

  assign link.sdo = sdo_shift_reg[15];

  // ----------------------------------------------------------------
  // alarms
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= '0;
      alarm_high <= 1'b0;
      alarm_low <= 1'b0;
    end else if (conv_strobe) begin
      result_reg <= conv_result;
      alarm_high <= conv_result > conv_high_limit;
      alarm_low <= conv_result < conv_low_limit;
    end
  end

  // ----------------------------------------------------------------
  // power down and range
  // ----------------------------------------------------------------
  logic pd_state_reg;
  logic pd_set;
  logic pd_clr;

  // sleep request ends the next full frame; pin low holds it down
  assign pd_set = (cfg_reg[PD_ASSIGN_BIT] && !pin_lvl[3]) ||
                  (frame_done && sleep_request_bit);
  assign pd_clr = cs_fall && !sleep_request_bit &&
                  !(cfg_reg[PD_ASSIGN_BIT] && !pin_lvl[3]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_state_reg <= 1'b0;
    end else if (pd_set) begin
      pd_state_reg <= 1'b1;
    end else if (pd_clr) begin
      pd_state_reg <= 1'b0;
    end
  end

  // raw pin path so power-down acts without a clock edge
  assign powered_down = pd_state_reg |
                        (cfg_reg[PD_ASSIGN_BIT] & ~aux_pin_in[3]);
  assign range_select = cfg_reg[RANGE_ASSIGN_BIT] ? pin_lvl[2] : range_bit_reg;

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  function automatic logic pin_special(input int idx, input logic [11:0] c);
    case (idx)
      0: pin_special = c[ALARM_B0] | c[ALARM_B1];
      1: pin_special = c[ALARM_B2] & ~c[ALARM_B0];
      2: pin_special = c[RANGE_ASSIGN_BIT];
      3: pin_special = c[PD_ASSIGN_BIT];
      default: pin_special = 1'b0;
    endcase
  endfunction

  logic [3:0] alarm_val;

  // pin zero: either limit on xx1, high limit on 010 or 110
  assign alarm_val[0] = cfg_reg[ALARM_B0] ? (alarm_high | alarm_low) : alarm_high;
  assign alarm_val[1] = alarm_low;
  assign alarm_val[2] = 1'b0;
  assign alarm_val[3] = 1'b0;

  // alarm pins drive, range and power-down pins only listen
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign aux_pin_oe[gi] = pin_special(gi, cfg_reg) ? (gi < 2) : cfg_reg[gi];
      assign aux_pin_out[gi] = pin_special(gi, cfg_reg) ? alarm_val[gi] :
                               pin_output_data[gi];
    end
  endgenerate
  // a single-pin part relies on the host writing legal codes
  // bits 11..10 are stored as written and steer nothing
endmodule // adcaux_device

// >>> design/adcaux_host.sv
// host controller end: APB registers driving the serial link
`timescale 1ns/1ns
module adcaux_host
  import adcaux_pkg::*;
#(
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // serial link
  adcaux_link_if.host link
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_TX) || (a == OFS_RX) || (a == OFS_STATUS) ||
             (a == OFS_INT_STATUS) || (a == OFS_INT_MASK);
  endfunction

  logic access;
  logic wr;
  adcaux_state_t state_reg;
  logic [15:0] tx_reg;
  logic [15:0] rx_reg;
  logic [1:0] int_status_reg;
  logic [1:0] int_mask_reg;
  logic [1:0] int_set;
  logic start;
  logic done;
  logic busy;

  assign access = psel & penable;
  assign wr = access & pwrite & mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped(paddr);
  assign busy = (state_reg != ADCAUX_IDLE);
  assign start = wr && (paddr == OFS_TX) && !busy;

  // read data set up in the setup cycle, steady through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        OFS_TX: prdata <= {16'h0000, tx_reg};
        OFS_RX: prdata <= {16'h0000, rx_reg};
        OFS_STATUS: prdata <= {31'h0000_0000, busy};
        OFS_INT_STATUS: prdata <= {30'h0000_0000, int_status_reg};
        OFS_INT_MASK: prdata <= {30'h0000_0000, int_mask_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt registers
  // ----------------------------------------------------------------
  assign int_set[INT_DONE] = done;
  assign int_set[INT_REFUSED] = wr && (paddr == OFS_TX) && busy;

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= INT_RESET;
      int_mask_reg <= INT_RESET;
    end else begin
      if (wr && paddr == OFS_INT_STATUS) begin
        int_status_reg <= (int_status_reg & ~pwdata[1:0]) | int_set;
      end else begin
        int_status_reg <= int_status_reg | int_set;
      end
      if (wr && paddr == OFS_INT_MASK) begin
        int_mask_reg <= pwdata[1:0];
      end
    end
  end

  assign irq = |(int_status_reg & int_mask_reg);

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  logic sdo_lvl;
  logic [7:0] div_reg;
  logic [4:0] bits_reg;
  logic tick;

  adcaux_sync #(.W(1)) u_sdo_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.sdo),
    .lvl(sdo_lvl),
    .rise(),
    .fall()
  );

  assign tick = (div_reg == 8'(HALF_CYCLES - 1));
  assign done = (state_reg == ADCAUX_GAP) && tick;

  // half-period divider, restarted on every phase change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
    end else if (!busy || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // sdo is sampled at the end of each high phase, after it settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ADCAUX_IDLE;
      tx_reg <= WORD_RESET;
      rx_reg <= WORD_RESET;
      bits_reg <= 5'h00;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.sdi <= 1'b0;
    end else begin
      case (state_reg)
        ADCAUX_IDLE: begin
          if (start) begin
            tx_reg <= pwdata[15:0];
            link.cs_n <= 1'b0;
            link.sdi <= pwdata[15];
            bits_reg <= 5'h00;
            state_reg <= ADCAUX_LEAD;
          end
        end
        ADCAUX_LEAD: begin
          if (tick) begin
            link.sclk <= 1'b1;
            state_reg <= ADCAUX_HIGH;
          end
        end
        ADCAUX_HIGH: begin
          if (tick) begin
            rx_reg <= {rx_reg[14:0], sdo_lvl};
            link.sclk <= 1'b0;
            bits_reg <= bits_reg + 5'h01;
            if (bits_reg == 5'(FRAME_BITS - 1)) begin
              link.cs_n <= 1'b1;
              state_reg <= ADCAUX_GAP;
            end else begin
              link.sdi <= tx_reg[4'(14 - bits_reg)];
              state_reg <= ADCAUX_LOW;
            end
          end
        end
        ADCAUX_LOW: begin
          if (tick) begin
            link.sclk <= 1'b1;
            state_reg <= ADCAUX_HIGH;
          end
        end
        ADCAUX_GAP: begin
          if (tick) begin
            state_reg <= ADCAUX_IDLE;
          end
        end
        default: begin
          state_reg <= ADCAUX_IDLE;
          link.cs_n <= 1'b1;
          link.sclk <= 1'b0;
        end
      endcase
    end
  end
endmodule // adcaux_host

// >>> testbench/adcaux_asserts.sv
// wire-level checks on the serial link between the two ends
`timescale 1ns/1ns
module adcaux_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo
);
  // --------
  // helper: sclk rises seen in the current frame
  // --------
  logic [4:0] rise_cnt;
  logic sclk_q;
  // cleared while deselected so a short frame cannot borrow old counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_cnt <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) rise_cnt <= 5'h00;
      else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_IDLE_LOW: assert property (cs_n |-> !sclk)
    else $error("sclk moved while deselected");
  AST_LEAD: assert property ($fell(cs_n) |-> !sclk [*6] ##1 sclk)
    else $error("lead-in half period wrong");
  AST_HIGH: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
    else $error("sclk high time wrong");
  AST_SIXTEEN: assert property ($rose(cs_n) |-> rise_cnt == 5'h10)
    else $error("frame is not sixteen bits");
  AST_END_EDGE: assert property ($rose(cs_n) |-> $fell(sclk))
    else $error("frame did not end on last sclk fall");
  AST_GAP: assert property ($rose(cs_n) |-> cs_n [*6])
    else $error("gap between frames too short");
  AST_FRAME_LEN: assert property ($fell(cs_n) |-> ##192 $rose(cs_n))
    else $error("frame length out of range");
  AST_SDI_HOLD: assert property (sclk |-> $stable(sdi))
    else $error("sdi changed while sclk high");
  AST_SDO_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdo))
    else $error("sdo changed while sclk high");
  // main scenarios reached
  cover property ($rose(cs_n));
  cover property (!cs_n && $rose(sdo));
  cover property ($rose(cs_n) ##[1:300] $fell(cs_n));
endmodule // adcaux_asserts

// >>> testbench/testbench.sv
// self-checking bench joining host and device ends of the link
`timescale 1ns/1ns
module testbench;
  import adcaux_pkg::*;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, irq, conv_strobe, ah, al;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] aux_pin_in, aux_pin_out, aux_pin_oe;
  logic [9:0] conv_result, conv_high_limit, conv_low_limit;
  logic powered_down, range_select, alarm_high, alarm_low;
  logic [11:0] pin_config, c;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int error_cnt = 0;
  int comparisons = 0;
  int seed;
  adcaux_link_if link_if ();
  adcaux_host adcaux_host_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .irq, .link(link_if.host));
  adcaux_device adcaux_device_inst (.pclk, .presetn, .link(link_if.dev), .aux_pin_in,
    .aux_pin_out, .aux_pin_oe, .conv_strobe, .conv_result, .conv_high_limit, .conv_low_limit,
    .powered_down, .range_select, .alarm_high, .alarm_low, .pin_config);
  adcaux_asserts adcaux_asserts_inst (.pclk, .presetn, .cs_n(link_if.cs_n),
    .sclk(link_if.sclk), .sdi(link_if.sdi), .sdo(link_if.sdo));
  // --------
  // helpers
  // --------
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic final_report();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one apb transfer; d is write data or the expected read data
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    exp_q.push_back({a > OFS_INT_MASK, d});
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // send one frame and wait for its done interrupt, bounded
  task automatic frame(input logic [15:0] f);
    int k;
    apb(OFS_TX, 1'b1, {16'h0000, f});
    for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge pclk);
    check(32'(irq), 32'h1);
    apb(OFS_INT_STATUS, 1'b1, 32'h1);
    repeat (8) @(posedge pclk);
  endtask
  // expected {drive enables, driven levels} for a configuration
  function automatic logic [7:0] pins(input logic [11:0] k, input logic [3:0] d);
    logic [3:0] oe;
    logic [3:0] o;
    oe = k[3:0];
    o = d;
    if (k[4] || k[5]) oe[0] = 1'b1;
    if (k[4]) o[0] = ah | al;
    else if (k[5]) o[0] = ah;
    if (k[6] && !k[4]) {oe[1], o[1]} = {1'b1, al};
    if (k[7]) oe[2] = 1'b0;
    if (k[8]) oe[3] = 1'b0;
    pins = {oe, o & oe};
  endfunction
  // read results are taken off the queue as each access completes
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) check(32'h0, 32'h1);
      else begin
        e = exp_q.pop_front();
        check(32'(pslverr), 32'(e[32]));
        if (!pwrite) check(prdata, e[31:0]);
      end
    end
  end
  // --------
  // clock, watchdog, sequence
  // --------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // a hung handshake ends here instead of running on
  initial begin
    #500000;
    error_cnt++;
    final_report();
  end
  initial begin
    seed = 44501;
    {presetn, psel, penable, pwrite, paddr, pwdata, conv_strobe, conv_result} = '0;
    {aux_pin_in, conv_high_limit, conv_low_limit} = {4'h8, 10'h200, 10'h100};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped 0x14 included
    for (int a = 0; a < 24; a += 4) apb(8'(a), 1'b0, 32'h0);
    check(32'({pin_config, aux_pin_oe, irq}), 32'h0);
    apb(OFS_INT_MASK, 1'b1, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      c = {3'b000, r[8:0]};
      if (i < 8) c[6:4] = i[2:0];
      aux_pin_in <= {1'b1, r[11:9]};
      conv_result <= r[21:12];
      conv_strobe <= 1'b1;
      @(posedge pclk);
      conv_strobe <= 1'b0;
      ah = r[21:12] > 10'h200;
      al = r[21:12] < 10'h100;
      frame({CMD_PIN_CFG, c});
      check(32'(pin_config), 32'(c));
      check(32'({alarm_high, alarm_low}), 32'({ah, al}));
      check(32'({aux_pin_oe, aux_pin_out & aux_pin_oe}), 32'(pins(c, 4'h0)));
      check(32'({range_select, powered_down}), 32'({c[7] & r[11], 1'b0}));
    end
    $display("test config done");
    r = $random(seed);
    aux_pin_in <= r[3:0];
    frame(16'h400F);
    frame({12'h101, r[7:4]});
    check(32'(aux_pin_out), 32'h0);
    frame({12'h100, r[11:8]});
    check(32'(aux_pin_out), 32'(r[7:4]));
    apb(OFS_RX, 1'b0, {16'h0, r[3:0], conv_result, 2'b00});
    frame(16'h400F);
    check(32'(aux_pin_out), 32'(r[11:8]));
    apb(OFS_RX, 1'b0, {20'h0, conv_result, 2'b00});
    frame(16'h1000);
    check(32'(aux_pin_out), 32'(r[11:8]));
    $display("test pin data done");
    frame(16'h4100);
    aux_pin_in[3] <= 1'b0;
    @(posedge pclk);
    #1 check(32'(powered_down), 32'h1);
    @(posedge pclk);
    aux_pin_in[3] <= 1'b1;
    repeat (6) @(posedge pclk);
    check(32'(powered_down), 32'h1);
    frame(16'h1000);
    check(32'(powered_down), 32'h0);
    frame(16'h3060);
    check(32'({range_select, powered_down}), 32'h2);
    frame(16'h2000);
    check(32'({range_select, powered_down}), 32'h1);
    frame(16'h420F);
    check(32'({pin_config, powered_down}), 32'h41E);
    frame(16'h1000);
    check(32'({pin_config, aux_pin_oe}), 32'h0);
    $display("test power and soft reset done");
    // refused write while busy, then mask and clear
    apb(OFS_INT_MASK, 1'b1, 32'h2);
    apb(OFS_TX, 1'b1, 32'h1000);
    apb(OFS_STATUS, 1'b0, 32'h1);
    apb(OFS_TX, 1'b1, 32'h1000);
    check(32'(irq), 32'h1);
    apb(OFS_INT_STATUS, 1'b0, 32'h2);
    apb(OFS_INT_STATUS, 1'b1, 32'h2);
    check(32'(irq), 32'h0);
    repeat (250) @(posedge pclk);
    apb(OFS_INT_STATUS, 1'b0, 32'h1);
    check(32'(irq), 32'h0);
    apb(OFS_INT_MASK, 1'b1, 32'h3);
    check(32'(irq), 32'h1);
    apb(OFS_INT_STATUS, 1'b1, 32'h1);
    check(32'(irq), 32'h0);
    apb(8'h14, 1'b1, 32'h5);
    apb(OFS_INT_MASK, 1'b0, 32'h3);
    $display("test interrupts done");
    final_report();
  end
endmodule // testbench
